//--- sdh_pkg.sv
/*
 * Shared constants for the SCSI DMA host interface: APB register offsets,
 * field positions, reset values and the transfer state machine type.
 * Assumes a 32-bit APB with one aligned word per register.
 */
package sdh_pkg;

   // ==========================================================
   // Register byte offsets on APB.
   localparam logic [7:0] OFS_DATA = 8'h00;
   localparam logic [7:0] OFS_INIT_CMD = 8'h04;
   localparam logic [7:0] OFS_MODE = 8'h08;
   localparam logic [7:0] OFS_TGT_CMD = 8'h0C;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_START_SEND = 8'h14;
   localparam logic [7:0] OFS_START_TRX = 8'h18;
   localparam logic [7:0] OFS_START_IRX = 8'h1C;
   localparam logic [7:0] OFS_CLEAR = 8'h20;

   // ==========================================================
   // Mode control register fields.
   localparam int MODE_DMA = 1;
   localparam int MODE_EOT_IE = 3;
   localparam int MODE_PAR_EN = 5;
   localparam int MODE_TARGET = 6;
   localparam int MODE_BLOCK = 7;
   localparam logic [7:0] MODE_WMASK = 8'hEA;

   // ==========================================================
   // Initiator and target command register fields.
   localparam int ICMD_DATA = 0;
   localparam int ICMD_ATN = 1;
   localparam int ICMD_ACK = 4;
   localparam logic [7:0] ICMD_WMASK = 8'h13;
   localparam int TCMD_REQ = 3;
   localparam int TCMD_LAST = 7;

   // ==========================================================
   // Transfer status register fields.
   localparam int STS_EOT = 7;
   localparam int STS_DRQ = 6;
   localparam int STS_PAR = 5;
   localparam int STS_IRQ = 4;
   localparam int STS_BUSY = 2;
   localparam int STS_ATN = 1;
   localparam int STS_ACK = 0;

   // ==========================================================
   // Reset values.
   localparam logic [7:0] MODE_RST = 8'h00;
   localparam logic [7:0] ICMD_RST = 8'h00;
   localparam logic [22:0] SYNC_RST = 23'h7FFE00;

   // Transfer state machine.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SEND_WAIT,
      ST_XFER1,
      ST_XFER2,
      ST_RECV_HOLD
   } sdh_state_e;

endpackage

//--- sdh_dma_core.sv
/*
 * SCSI DMA host interface: APB register slave, programmed I/O drive of the
 * SCSI control lines, normal and block mode DMA toward an external DMA
 * controller, end-of-process handling, parity and end-of-transfer flags.
 * Assumes the DMA controller and SCSI pins are asynchronous to pclk; every
 * pin input passes a two-stage synchroniser. The busy error event comes from
 * logic on pclk.
 */
`timescale 1ns/1ps

// Function
// - Parity flag is status bit 5; parity enable off masks and blocks it.
// - Reading the clear location clears the parity error flag.
// - End-of-process counts only with grant and a read or write strobe.
// - Valid end-of-process in DMA mode sets end-of-transfer flag, status bit 7.
// - End-of-transfer interrupt enable masks only the interrupt, not the flag.
// - Clearing DMA mode clears the end-of-transfer flag.
// - Programmed I/O drives SCSI lines from command register bits.
// - Normal mode is DMA on, block off; started by three start locations.
// - After start, internal machine runs REQ/ACK handshake alone.
// - Request when a byte can move; grant plus read or write strobe answers.
// - Write data captured when grant-and-write condition is released.
// - Transfer ends by valid end-of-process or clearing DMA mode.
// - Block mode: controller waits for ready before completing a cycle.
// - Block send: ready low while output byte not yet sent.
// - Block receive: ready low while input register empty.
// - Block mode: grant may stay low; request still raised normally.
// - Send stops after the byte loaded with end-of-process.
// - Last-byte-sent flag in target command register.
// - End-of-process keeps DMA mode; machine idles until next start.
// - Clear location read also clears interrupt and busy flags.
// - Clearing DMA mode resets the machine at once, drops request.
// - Block mode: ready stays high when DMA mode is cleared.
// - End-of-process: ready after final send byte, at once on receive.
module sdh_dma_core (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // DMA controller side
   input wire logic dma_grant_n,
   input wire logic host_read_strobe_n,
   input wire logic host_write_strobe_n,
   input wire logic transfer_done_strobe_n,
   input wire logic [7:0] host_data_in,
   output logic [7:0] host_data_out,
   output logic dma_request,
   output logic ready,
   output logic irq,
   // SCSI side
   input wire logic scsi_req_n_in,
   input wire logic scsi_ack_n_in,
   input wire logic [7:0] scsi_data_in,
   input wire logic scsi_parity_in,
   output logic scsi_req_n_out,
   output logic scsi_ack_n_out,
   output logic scsi_atn_n_out,
   output logic [7:0] scsi_data_out,
   output logic scsi_parity_out,
   output logic scsi_data_oe_n,
   // Busy monitor
   input wire logic busy_error_event
);
   import sdh_pkg::*;

   // ==========================================================
   // Pin synchronisers
   logic [22:0] sync1_reg, sync2_reg;
   wire [22:0] pins = {dma_grant_n, host_read_strobe_n, host_write_strobe_n,
      transfer_done_strobe_n, scsi_req_n_in, scsi_ack_n_in, scsi_parity_in,
      scsi_data_in, host_data_in};

   // Two flops per pin; only the second stage is read by logic.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= SYNC_RST;
         sync2_reg <= SYNC_RST;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
      end
   end

   wire grant_n_s = sync2_reg[22];
   wire rd_n_s = sync2_reg[21];
   wire wr_n_s = sync2_reg[20];
   wire eop_n_s = sync2_reg[19];
   wire req_n_s = sync2_reg[18];
   wire ack_n_s = sync2_reg[17];
   wire par_s = sync2_reg[16];
   wire [7:0] sdata_s = sync2_reg[15:8];
   wire [7:0] hdata_s = sync2_reg[7:0];

   // ==========================================================
   // Registers and state
   sdh_state_e state_reg, state_next;
   logic [7:0] mode_reg, icmd_reg;
   logic [7:0] out_data_reg, wdata_reg, in_data_reg, sdo_reg;
   logic out_full_reg, in_full_reg, send_reg, target_reg, eop_pend_reg, last_reg;
   logic eot_reg, par_err_reg, irq_flag_reg, busy_err_reg;
   logic wr_act_q, rd_act_q, eop_q, pio_req_reg;
   logic pready_reg, pslverr_reg;
   logic [31:0] prdata_reg;
   logic drq_reg, ready_reg, req_out_reg, ack_out_reg, oe_n_reg, atn_n_reg, par_out_reg;

   // ==========================================================
   // APB decode
   wire setup = psel && !penable;
   wire done = psel && penable && pready_reg;
   wire wr_en = done && pwrite;
   wire rd_en = done && !pwrite;
   wire addr_ok = (paddr[1:0] == 2'h0) && (paddr <= OFS_CLEAR);
   wire wr_mode = wr_en && (paddr == OFS_MODE);
   wire wr_icmd = wr_en && (paddr == OFS_INIT_CMD);
   wire wr_tcmd = wr_en && (paddr == OFS_TGT_CMD);
   wire wr_data = wr_en && (paddr == OFS_DATA);
   wire rd_clear = rd_en && (paddr == OFS_CLEAR);
   wire rd_data = rd_en && (paddr == OFS_DATA);
   wire dma_mode = mode_reg[MODE_DMA];
   wire block = mode_reg[MODE_BLOCK];
   // Start writes are honoured only with DMA mode already on.
   wire start_send = wr_en && (paddr == OFS_START_SEND) && dma_mode;
   wire start_trx = wr_en && (paddr == OFS_START_TRX) && dma_mode;
   wire start_irx = wr_en && (paddr == OFS_START_IRX) && dma_mode;
   wire start_any = start_send || start_trx || start_irx;

   // Read multiplexer; start and clear locations read as zero.
   wire [7:0] status_byte = {eot_reg, drq_reg, par_err_reg, irq_flag_reg, 1'b0,
      busy_err_reg, ~scsi_atn_n_out, ~ack_n_s};
   wire [7:0] tcmd_byte = {last_reg, 3'h0, pio_req_reg, 3'h0};
   wire [7:0] rd_byte = (paddr == OFS_DATA) ? in_data_reg :
                        (paddr == OFS_INIT_CMD) ? icmd_reg :
                        (paddr == OFS_MODE) ? mode_reg :
                        (paddr == OFS_TGT_CMD) ? tcmd_byte :
                        (paddr == OFS_STATUS) ? status_byte : 8'h00;

   // No wait states: pready rises in the first access cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup && !addr_ok;
         prdata_reg <= (setup && !pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      end
   end

   // ==========================================================
   // DMA strobe decode
   wire wr_act = !grant_n_s && !wr_n_s;
   wire rd_act = !grant_n_s && !rd_n_s;
   wire wr_release = wr_act_q && !wr_act;
   wire rd_release = rd_act_q && !rd_act;
   // Any other end-of-process assertion never reaches the flags.
   wire eop_valid = !eop_n_s && !grant_n_s && (!rd_n_s || !wr_n_s);
   wire eop_rise = eop_valid && !eop_q;
   wire active = (state_reg != ST_IDLE);

   // ==========================================================
   // SCSI handshake decode
   // Target waits on ACK, initiator on REQ; own strobe active in the phase
   // where it leads (target) or answers (initiator).
   wire peer_act = target_reg ? !ack_n_s : !req_n_s;
   wire in_xfer = (state_reg == ST_XFER1) || (state_reg == ST_XFER2);
   wire own_act = in_xfer && ((state_reg == ST_XFER1) == target_reg);
   wire latch_now = (state_reg == ST_XFER1) && peer_act && !send_reg;
   wire byte_gone = (state_reg == ST_XFER2) && !peer_act && send_reg;
   wire par_bad = ~^{~sdata_s, ~par_s};
   wire par_set = mode_reg[MODE_PAR_EN] && par_bad && (latch_now || rd_data);
   wire eot_set = dma_mode && eop_rise;
   wire irq_set = (eot_set && mode_reg[MODE_EOT_IE]) || par_set;

   // ==========================================================
   // Transfer state machine
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: state_next = ST_IDLE;
         ST_SEND_WAIT: if (out_full_reg) state_next = ST_XFER1;
         ST_XFER1: if (peer_act) state_next = ST_XFER2;
         ST_XFER2: begin
            if (!peer_act) begin
               if (!send_reg) state_next = ST_RECV_HOLD;
               else if (eop_pend_reg) state_next = ST_IDLE;
               else state_next = ST_SEND_WAIT;
            end
         end
         ST_RECV_HOLD: if (!in_full_reg) state_next = ST_XFER1;
         default: state_next = ST_IDLE;
      endcase
      // Receive ends at once on a valid end-of-process.
      if (eot_set && !send_reg) state_next = ST_IDLE;
      if (start_send) state_next = ST_SEND_WAIT;
      if (start_trx || start_irx) state_next = ST_XFER1;
      // Mode clear is a hard reset of the machine; it overrides a start.
      if (!dma_mode) state_next = ST_IDLE;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) state_reg <= ST_IDLE;
      else state_reg <= state_next;
   end

   // ==========================================================
   // Software registers and strobe history
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_reg <= MODE_RST;
         icmd_reg <= ICMD_RST;
         pio_req_reg <= 1'b0;
         wr_act_q <= 1'b0;
         rd_act_q <= 1'b0;
         eop_q <= 1'b0;
      end else begin
         if (wr_mode) mode_reg <= pwdata[7:0] & MODE_WMASK;
         if (wr_icmd) icmd_reg <= pwdata[7:0] & ICMD_WMASK;
         if (wr_tcmd) pio_req_reg <= pwdata[TCMD_REQ];
         wr_act_q <= wr_act;
         rd_act_q <= rd_act;
         eop_q <= eop_valid;
      end
   end

   // ==========================================================
   // Transfer bookkeeping
   // Direction and role are fixed at start; send role follows the mode bit.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         send_reg <= 1'b0;
         target_reg <= 1'b0;
         eop_pend_reg <= 1'b0;
         last_reg <= 1'b0;
      end else begin
         if (start_any) begin
            send_reg <= start_send;
            target_reg <= start_send ? mode_reg[MODE_TARGET] : start_trx;
         end
         if (start_any || !dma_mode) eop_pend_reg <= 1'b0;
         else if (eot_set && send_reg && active) eop_pend_reg <= 1'b1;
         if (start_any) last_reg <= 1'b0;
         else if (byte_gone && eop_pend_reg) last_reg <= 1'b1;
      end
   end

   // ==========================================================
   // Data registers
   // Host data is staged while the strobe is active and committed only on
   // release, so a byte still waiting for the SCSI side is never overwritten by host data.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdata_reg <= 8'h00;
         out_data_reg <= 8'h00;
         out_full_reg <= 1'b0;
         in_data_reg <= 8'h00;
         in_full_reg <= 1'b0;
      end else begin
         if (wr_act) wdata_reg <= hdata_s;
         if (wr_data) out_data_reg <= pwdata[7:0];
         else if (wr_release && state_reg == ST_SEND_WAIT && !out_full_reg)
            out_data_reg <= wdata_reg;
         if (start_any || !dma_mode || byte_gone) out_full_reg <= 1'b0;
         else if (wr_release && state_reg == ST_SEND_WAIT) out_full_reg <= 1'b1;
         // Pins are low-true; the register holds the true byte.
         if (latch_now) in_data_reg <= ~sdata_s;
         if (latch_now) in_full_reg <= 1'b1;
         else if (rd_release || start_any) in_full_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Status flags; a set in the same cycle as a clear wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         eot_reg <= 1'b0;
         par_err_reg <= 1'b0;
         irq_flag_reg <= 1'b0;
         busy_err_reg <= 1'b0;
      end else begin
         if (eot_set) eot_reg <= 1'b1;
         else if (!dma_mode) eot_reg <= 1'b0;
         if (par_set) par_err_reg <= 1'b1;
         else if (rd_clear) par_err_reg <= 1'b0;
         if (irq_set) irq_flag_reg <= 1'b1;
         else if (rd_clear) irq_flag_reg <= 1'b0;
         if (busy_error_event) busy_err_reg <= 1'b1;
         else if (rd_clear) busy_err_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Request, ready and SCSI drive
   // Normal mode drops the request on grant; block mode keeps it, since the
   // grant may stay low for the whole block and ready does the throttling.
   wire drq_next = dma_mode && (block || grant_n_s) &&
      (((state_reg == ST_SEND_WAIT) && !out_full_reg) ||
       ((state_reg == ST_RECV_HOLD) && in_full_reg));
   // Ready holds off the controller only while a block transfer runs; idle
   // or mode cleared leaves it high so the bus never locks up.
   wire ready_hold = block && dma_mode && active &&
      (send_reg ? out_full_reg : !in_full_reg);
   wire ack_next = !(icmd_reg[ICMD_ACK] || (own_act && !target_reg));
   wire req_next = !(pio_req_reg || (own_act && target_reg));
   wire oe_next = !(icmd_reg[ICMD_DATA] || (in_xfer && send_reg));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         drq_reg <= 1'b0;
         ready_reg <= 1'b1;
         req_out_reg <= 1'b1;
         ack_out_reg <= 1'b1;
         oe_n_reg <= 1'b1;
         atn_n_reg <= 1'b1;
         sdo_reg <= 8'hFF;
         par_out_reg <= 1'b0;
      end else begin
         drq_reg <= drq_next;
         ready_reg <= !ready_hold;
         req_out_reg <= req_next;
         ack_out_reg <= ack_next;
         oe_n_reg <= oe_next;
         atn_n_reg <= !icmd_reg[ICMD_ATN];
         sdo_reg <= ~out_data_reg;
         par_out_reg <= ^out_data_reg;
      end
   end

   // Every cable output leaves a flop, so no decode glitch reaches the bus.
   assign scsi_atn_n_out = atn_n_reg;
   assign scsi_data_out = sdo_reg;
   assign scsi_parity_out = par_out_reg;
   assign scsi_data_oe_n = oe_n_reg;
   assign scsi_req_n_out = req_out_reg;
   assign scsi_ack_n_out = ack_out_reg;
   assign dma_request = drq_reg;
   assign ready = ready_reg;
   assign irq = irq_flag_reg;
   assign host_data_out = in_data_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;

   // ==========================================================
   // Assertions
   sequence s_final_byte;
      byte_gone && eop_pend_reg && dma_mode && !start_any;
   endsequence

   AST_PAR_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      (!mode_reg[MODE_PAR_EN] && !par_err_reg) |=> !par_err_reg)
      else $error("parity flag set while checking disabled");
   AST_PAR_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (rd_clear && !par_set) |=> !par_err_reg)
      else $error("parity flag survived clear read");
   AST_EOP_QUAL: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(eot_reg) |-> $past(!eop_n_s && !grant_n_s && (!rd_n_s || !wr_n_s)))
      else $error("end flag rose without qualified end strobe");
   AST_EOT_SET: assert property (@(posedge pclk) disable iff (!presetn)
      eot_set |=> eot_reg && status_byte[STS_EOT])
      else $error("end flag not set by valid end strobe");
   AST_EOT_MASK: assert property (@(posedge pclk) disable iff (!presetn)
      (eot_set && !mode_reg[MODE_EOT_IE] && !par_set && !irq_flag_reg)
      |=> (!irq && eot_reg))
      else $error("masked end interrupt reached irq");
   AST_MODE_CLR: assert property (@(posedge pclk) disable iff (!presetn)
      (!dma_mode && !eop_rise) |=> (!eot_reg && state_reg == ST_IDLE ##1 !dma_request))
      else $error("mode clear did not reset flag and machine");
   AST_DRQ_DROP: assert property (@(posedge pclk) disable iff (!presetn)
      (!block && !grant_n_s) |=> !dma_request)
      else $error("request held during grant in normal mode");
   AST_RDY_SEND: assert property (@(posedge pclk) disable iff (!presetn)
      (ready_hold && send_reg) |=> !ready)
      else $error("ready high with unsent byte");
   AST_RDY_MODECLR: assert property (@(posedge pclk) disable iff (!presetn)
      !dma_mode |=> ready)
      else $error("ready low after mode clear");
   AST_WCAP: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_release && state_reg == ST_SEND_WAIT && !out_full_reg && !wr_data && dma_mode
       && !start_any) |=> (out_full_reg && out_data_reg == $past(wdata_reg)))
      else $error("write byte not captured on release");
   AST_LAST_BYTE: assert property (@(posedge pclk) disable iff (!presetn)
      s_final_byte |=> (last_reg && state_reg == ST_IDLE && dma_mode) ##1 !drq_reg)
      else $error("final byte did not idle machine");
   AST_IRQ_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      (irq && !rd_clear) |=> irq)
      else $error("irq dropped without clear read");
endmodule

//--- sdh_dma_ctl_model.sv
/*
 * Behavioural DMA controller facing the SCSI DMA host interface.
 * Assumes the bench supplies pclk and raises start for one transfer at a time.
 */
`timescale 1ns/1ps
module sdh_dma_ctl_model (
   // Bench control
   input wire logic pclk,
   input wire logic start,
   input wire logic wr,
   input wire logic with_end,
   input wire logic lone,
   input wire logic [7:0] wdata,
   output logic done,
   output logic [7:0] rdata,
   // Device pins
   input wire logic dma_request,
   input wire logic ready,
   input wire logic [7:0] host_data_out,
   output logic dma_grant_n,
   output logic host_read_strobe_n,
   output logic host_write_strobe_n,
   output logic transfer_done_strobe_n,
   output logic [7:0] host_data_in
);
   // ==========================================================
   // One byte per request; strobes held at least four cycles, and until ready is high, so the synchronisers see them.
   initial begin
      {dma_grant_n, host_read_strobe_n, host_write_strobe_n} = 3'h7;
      transfer_done_strobe_n = 1'b1;
      done = 1'b0;
      rdata = 8'h00;
      host_data_in = 8'h00;
      forever begin
         @(posedge pclk);
         if (start && (dma_request || lone)) begin
            dma_grant_n <= 1'b0;
            host_write_strobe_n <= !(wr && !lone);
            host_read_strobe_n <= !(!wr && !lone);
            transfer_done_strobe_n <= !with_end;
            host_data_in <= wdata;
            repeat (4) @(posedge pclk);
            while (ready !== 1'b1) @(posedge pclk);
            rdata <= host_data_out;
            {dma_grant_n, host_read_strobe_n, host_write_strobe_n} <= 3'h7;
            transfer_done_strobe_n <= 1'b1;
            // Released data lines show the inverse so stale data cannot pass.
            host_data_in <= ~wdata;
            done <= 1'b1;
            @(posedge pclk);
            done <= 1'b0;
            repeat (4) @(posedge pclk);
         end
      end
   end
endmodule

//--- scsi_dma_host_interface_test.sv
/*
 * Self-checking bench: APB master, SCSI target peer and DMA controller model.
 * Assumes the core answers APB in one access cycle and idles after a transfer end.
 */
`timescale 1ns/1ps
module scsi_dma_host_interface_test;
   import sdh_pkg::*;
   localparam logic [31:0] SM = 32'hB4;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, ready, dma_request;
   logic [7:0] paddr, sdi, sdo, hdi, hdo, wdata, rdata, sent, b;
   logic [31:0] pwdata, prdata, rd, seed;
   logic er, start, wr, with_end, lone, done, peer_on, req_n, ack_n, ack_q;
   logic g_n, r_n, w_n, e_n, spi, rq_o, atn_o, po, oe_o;
   int fails, samples_checked, acks, i, n;

   sdh_dma_core sdh_dma_core_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .dma_grant_n(g_n), .host_read_strobe_n(r_n),
      .host_write_strobe_n(w_n), .transfer_done_strobe_n(e_n), .host_data_in(hdi),
      .host_data_out(hdo), .dma_request(dma_request), .ready(ready), .irq(irq),
      .scsi_req_n_in(req_n), .scsi_ack_n_in(1'b1), .scsi_data_in(sdi),
      .scsi_parity_in(spi), .scsi_req_n_out(rq_o), .scsi_ack_n_out(ack_n),
      .scsi_atn_n_out(atn_o), .scsi_data_out(sdo), .scsi_parity_out(po),
      .scsi_data_oe_n(oe_o),
      .busy_error_event(1'b0));
   sdh_dma_ctl_model sdh_dma_ctl_model_inst (.pclk(pclk), .start(start), .wr(wr),
      .with_end(with_end), .lone(lone), .wdata(wdata), .done(done), .rdata(rdata),
      .dma_request(dma_request), .ready(ready), .host_data_out(hdo), .dma_grant_n(g_n),
      .host_read_strobe_n(r_n), .host_write_strobe_n(w_n),
      .transfer_done_strobe_n(e_n), .host_data_in(hdi));

   // ==========================================================
   // Clock, and a SCSI target peer that answers every ACK edge.
   initial begin
      pclk = 1'b0;
      forever #10 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      req_n <= !peer_on || !ack_n;
      ack_q <= ack_n;
      if (ack_q && !ack_n) begin
         acks <= acks + 1;
         sent <= ~sdo;
      end
   end

   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction

   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      samples_checked++;
      if (got !== ex) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Holds the request until pready is sampled high, then releases it.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) begin
         fails++;
         end_of_test();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic xfer(input logic w, input logic e, input logic l, input logic [7:0] d);
      int k;
      wr <= w;
      with_end <= e;
      lone <= l;
      wdata <= d;
      // No APB transfer is open while the controller drives grant.
      start <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (done !== 1'b1 && k < 3000);
      if (k >= 3000) begin
         fails++;
         end_of_test();
      end
      start <= 1'b0;
   endtask

   function automatic logic [31:0] sx(input logic eot, input logic iq);
      return (32'(eot) << STS_EOT) | (32'(iq) << STS_IRQ);
   endfunction

   task automatic end_of_test();
      if (fails == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   initial begin
      repeat (40000) @(posedge pclk);
      fails++;
      end_of_test();
   end

   // ==========================================================
   // Main sequence.
   initial begin
      {psel, penable, pwrite, start, wr, with_end, lone, peer_on} = 8'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      wdata = 8'h00;
      sdi = 8'hFF;
      spi = 1'b0;
      seed = 32'h0000_0046;
      presetn = 1'b0;
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_STATUS, 0);
      chk("status", 0, rd & SM);
      chk("ready", 1, ready);
      apb(0, 8'h24, 0);
      chk("slverr", 1, er);
      apb(1, OFS_MODE, (32'h1 << MODE_DMA) | (32'h1 << MODE_EOT_IE));
      apb(1, OFS_START_SEND, 0);
      peer_on <= 1'b1;
      for (i = 0; i < 2; i++) begin
         b = xs();
         xfer(1'b1, i[0], 1'b0, b);
         n = 0;
         while (acks < i + 1 && n < 500) begin
            @(posedge pclk);
            n++;
         end
         chk("sent", b, sent);
      end
      n = 0;
      do begin
         apb(0, OFS_TGT_CMD, 0);
         n++;
      end while (rd[TCMD_LAST] !== 1'b1 && n < 40);
      chk("last", 1, rd[TCMD_LAST]);
      apb(0, OFS_STATUS, 0);
      chk("status", sx(1, 1), rd & SM);
      chk("irq", 1, irq);
      apb(0, OFS_MODE, 0);
      chk("mode", 1, rd[MODE_DMA]);
      repeat (30) @(posedge pclk);
      chk("acks", 2, acks);
      apb(1, OFS_MODE, 0);
      apb(0, OFS_STATUS, 0);
      chk("status", sx(0, 1), rd & SM);
      apb(0, OFS_CLEAR, 0);
      apb(0, OFS_STATUS, 0);
      chk("status", 0, rd & SM);
      chk("irq", 0, irq);
      peer_on <= 1'b0;
      b = xs();
      sdi <= ~b;
      apb(1, OFS_MODE, 32'h1 << MODE_DMA);
      apb(1, OFS_START_IRX, 0);
      peer_on <= 1'b1;
      xfer(1'b0, 1'b1, 1'b0, 8'h00);
      chk("recv", b, rdata);
      apb(0, OFS_STATUS, 0);
      chk("status", sx(1, 0), rd & SM);
      chk("irq", 0, irq);
      apb(1, OFS_MODE, 0);
      apb(1, OFS_MODE, 32'h1 << MODE_DMA);
      xfer(1'b0, 1'b1, 1'b1, 8'h00);
      apb(0, OFS_STATUS, 0);
      chk("status", 0, rd & SM);
      // Block receive: ready holds the controller until a byte is in.
      peer_on <= 1'b0;
      apb(1, OFS_MODE, (32'h1 << MODE_DMA) | (32'h1 << MODE_BLOCK));
      apb(1, OFS_START_IRX, 0);
      repeat (4) @(posedge pclk);
      chk("ready", 0, ready);
      peer_on <= 1'b1;
      xfer(1'b0, 1'b1, 1'b0, 8'h00);
      chk("recv", b, rdata);
      repeat (4) @(posedge pclk);
      chk("ready", 1, ready);
      // Bad parity on a data read flags only while checking is enabled.
      spi <= ~^b;
      apb(1, OFS_MODE, 0);
      apb(0, OFS_DATA, 0);
      apb(0, OFS_STATUS, 0);
      chk("status", 0, rd & SM);
      apb(1, OFS_MODE, 32'h1 << MODE_PAR_EN);
      apb(0, OFS_DATA, 0);
      apb(0, OFS_STATUS, 0);
      chk("status", sx(0, 1) | (32'h1 << STS_PAR), rd & SM);
      apb(0, OFS_CLEAR, 0);
      apb(0, OFS_STATUS, 0);
      chk("status", 0, rd & SM);
      // Programmed I/O: command bits drive the cable lines.
      apb(1, OFS_DATA, {24'h00_0000, b});
      apb(1, OFS_INIT_CMD, {24'h00_0000, ICMD_WMASK});
      apb(1, OFS_TGT_CMD, 32'h1 << TCMD_REQ);
      repeat (2) @(posedge pclk);
      chk("pio", {~b, ^b, 4'h0}, {sdo, po, ack_n, atn_o, rq_o, oe_o});
      chk("drq", 0, dma_request);
      end_of_test();
   end
endmodule
